// >>> inc/shift_reg_pkg.sv
// constants and types shared by the four-stage universal shift register
// What this block does
// - both selects high loads parallel data
// - parallel load ignores both serial inputs
// - first select only shifts toward last stage
// - second select only shifts toward first stage
// - serial data captured only on rising edge
// - three-state variant: all-low modes clear stages
// - three-state variant: output enable low floats outputs, logic continues
// - reset variant: all-low modes hold contents
// - reset variant: reset low clears stages immediately, outputs low
// - four stages, each with input and output
package shift_reg_pkg;
  localparam int STAGES = 4;
  localparam logic [STAGES-1:0] STAGE_RESET = 4'h0;
  localparam int SYNC_DEPTH = 2;
  // variant codes
  localparam int VARIANT_TRISTATE = 0;
  localparam int VARIANT_ASYNC_RESET = 1;
  // positions inside the sampled pin vector
  localparam int POS_MODE = 0;
  localparam int POS_SER_RIGHT = 2;
  localparam int POS_SER_LEFT = 3;
  localparam int POS_PAR = 4;
  localparam int POS_OE = POS_PAR + STAGES;
  localparam int PIN_WIDTH = POS_OE + 1;
  // bit 0 is the first select, bit 1 the second
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_RIGHT = 2'b01,
    MODE_LEFT = 2'b10,
    MODE_LOAD = 2'b11
  } mode_t;
endpackage

// >>> inc/pin_sync_if.sv
// carrier between the pin sampler and the shift register core
`timescale 1ns/10ps
`default_nettype none
interface pin_sync_if #(parameter int WIDTH = 1);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] synced;
  modport sampler(input raw, output synced);
  modport user(output raw, input synced);
endinterface
`default_nettype wire

// >>> rtl/pin_sync.sv
// two-flop sampler for the asynchronous pins of the shift register
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // pins in, sampled pins out
  pin_sync_if.sampler pins
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] settled;

  if (WIDTH < 1) begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // first flop feeds only the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta <= '0;
    end else begin
      meta <= pins.raw;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      settled <= '0;
    end else begin
      settled <= meta;
    end
  end

  assign pins.synced = settled;

  property p_two_flop_delay;
    @(posedge clk_sys) disable iff (sys_rst)
    !$past(sys_rst) && !$past(sys_rst, 2)
      |-> settled == $past(pins.raw, 2);
  endproperty
  a_two_flop_delay: assert property (p_two_flop_delay)
    else $error("sampled pins do not lag raw pins by two cycles");
endmodule // pin_sync
`default_nettype wire

// >>> rtl/universal_shift_register_4bit.sv
// four-stage bidirectional universal shift register core
`timescale 1ns/10ps
`default_nettype none
module universal_shift_register_4bit #(
  parameter int VARIANT = shift_reg_pkg::VARIANT_TRISTATE,
  parameter int STAGES = shift_reg_pkg::STAGES
) (
  // clock and synchronous reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // mode selects
  input wire logic mode_select_first,
  input wire logic mode_select_second,
  // serial inputs
  input wire logic serial_in_rightward,
  input wire logic serial_in_leftward,
  // parallel data, bit 0 is the first stage
  input wire logic [STAGES-1:0] parallel_in,
  // variant controls
  input wire logic output_enable,
  input wire logic master_reset_n,
  // stage outputs
  output logic [STAGES-1:0] stage_out,
  output logic stage_out_oe_n
);
  localparam int PW = shift_reg_pkg::PIN_WIDTH;

  pin_sync_if #(.WIDTH(PW)) pins ();

  logic [STAGES-1:0] stage;
  logic [STAGES-1:0] next_stage;
  logic [PW-1:0] sampled;
  shift_reg_pkg::mode_t mode;
  logic ser_right;
  logic ser_left;
  logic [STAGES-1:0] par;
  logic oe;
  logic async_clr_n;

  function automatic shift_reg_pkg::mode_t decode_mode(
    input logic [1:0] sel
  );
    return shift_reg_pkg::mode_t'(sel);
  endfunction

  function automatic logic is_variant(input int v);
    return VARIANT == v;
  endfunction

  if (STAGES != shift_reg_pkg::STAGES) begin : g_bad_stages
    $error("stage count must match the package layout");
  end
  if (!is_variant(shift_reg_pkg::VARIANT_TRISTATE) &&
      !is_variant(shift_reg_pkg::VARIANT_ASYNC_RESET)) begin : g_bad_var
    $error("unknown variant");
  end

  // every pin except master_reset_n passes two flops before the core reads it
  assign pins.raw = {output_enable, parallel_in, serial_in_leftward,
                     serial_in_rightward, mode_select_second,
                     mode_select_first};

  pin_sync #(.WIDTH(PW)) u_pin_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pins(pins)
  );

  assign sampled = pins.synced;
  assign mode = decode_mode(sampled[shift_reg_pkg::POS_MODE +: 2]);
  assign ser_right = sampled[shift_reg_pkg::POS_SER_RIGHT];
  assign ser_left = sampled[shift_reg_pkg::POS_SER_LEFT];
  assign par = sampled[shift_reg_pkg::POS_PAR +: STAGES];
  assign oe = sampled[shift_reg_pkg::POS_OE];

  // the direct clear exists only in the reset variant
  assign async_clr_n = is_variant(shift_reg_pkg::VARIANT_ASYNC_RESET) ?
                       master_reset_n : 1'b1;

  always_comb begin
    case (mode)
      shift_reg_pkg::MODE_LOAD: begin
        next_stage = par;
      end
      shift_reg_pkg::MODE_RIGHT: begin
        next_stage = {stage[STAGES-2:0], ser_right};
      end
      shift_reg_pkg::MODE_LEFT: begin
        next_stage = {ser_left, stage[STAGES-1:1]};
      end
      shift_reg_pkg::MODE_IDLE: begin
        if (is_variant(shift_reg_pkg::VARIANT_TRISTATE)) begin
          next_stage = shift_reg_pkg::STAGE_RESET;
        end else begin
          next_stage = stage;
        end
      end
      default: begin
        next_stage = stage;
      end
    endcase
  end

  // release of the direct clear is not synchronised: keep it clear of
  // clock edges, as for any asynchronous clear
  always_ff @(posedge clk_sys or negedge async_clr_n) begin
    if (!async_clr_n) begin
      stage <= shift_reg_pkg::STAGE_RESET;
    end else if (sys_rst) begin
      stage <= shift_reg_pkg::STAGE_RESET;
    end else begin
      stage <= next_stage;
    end
  end

  assign stage_out = stage;
  // enable active low: in the three-state variant pins float while the sampled enable is low
  assign stage_out_oe_n = is_variant(shift_reg_pkg::VARIANT_TRISTATE) ?
                          ~oe : 1'b0;

  // checks on the register behaviour
  property p_load;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    mode == shift_reg_pkg::MODE_LOAD |=> stage == $past(par);
  endproperty
  a_load: assert property (p_load)
    else $error("parallel load did not capture the data");

  property p_load_no_serial;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    mode == shift_reg_pkg::MODE_LOAD && ser_right != par[0]
      |=> stage[0] != $past(ser_right);
  endproperty
  a_load_no_serial: assert property (p_load_no_serial)
    else $error("serial data entered during parallel load");

  property p_right;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    mode == shift_reg_pkg::MODE_RIGHT
      |=> stage == {$past(stage[STAGES-2:0]), $past(ser_right)};
  endproperty
  a_right: assert property (p_right)
    else $error("shift toward last stage wrong");

  property p_left;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    mode == shift_reg_pkg::MODE_LEFT
      |=> stage == {$past(ser_left), $past(stage[STAGES-1:1])};
  endproperty
  a_left: assert property (p_left)
    else $error("shift toward first stage wrong");

  property p_serial_source;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    mode == shift_reg_pkg::MODE_RIGHT ##1
      mode == shift_reg_pkg::MODE_LEFT
      |=> stage[0] == $past(stage[1]) &&
          stage[STAGES-1] == $past(ser_left);
  endproperty
  a_serial_source: assert property (p_serial_source)
    else $error("serial input taken from the wrong side");

  property p_clear;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    is_variant(shift_reg_pkg::VARIANT_TRISTATE) &&
      mode == shift_reg_pkg::MODE_IDLE
      |=> stage == shift_reg_pkg::STAGE_RESET;
  endproperty
  a_clear: assert property (p_clear)
    else $error("all-low modes did not clear the stages");

  property p_float_keeps_running;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    is_variant(shift_reg_pkg::VARIANT_TRISTATE) && !oe &&
      mode == shift_reg_pkg::MODE_LOAD
      |-> stage_out_oe_n ##1 stage == $past(par);
  endproperty
  a_float_keeps_running: assert property (p_float_keeps_running)
    else $error("disabled outputs not floated or logic stalled");

  property p_hold;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    is_variant(shift_reg_pkg::VARIANT_ASYNC_RESET) &&
      mode == shift_reg_pkg::MODE_IDLE |=> $stable(stage);
  endproperty
  a_hold: assert property (p_hold)
    else $error("all-low modes did not hold the stages");

  property p_direct_clear;
    @(posedge clk_sys) disable iff (sys_rst)
    is_variant(shift_reg_pkg::VARIANT_ASYNC_RESET) && !master_reset_n
      |-> stage_out == shift_reg_pkg::STAGE_RESET && !stage_out_oe_n;
  endproperty
  a_direct_clear: assert property (p_direct_clear)
    else $error("outputs not low while reset held");

  property p_shift_out_four;
    @(posedge clk_sys) disable iff (sys_rst || !async_clr_n)
    (mode == shift_reg_pkg::MODE_RIGHT && !ser_right) [*4]
      |=> stage == shift_reg_pkg::STAGE_RESET;
  endproperty
  a_shift_out_four: assert property (p_shift_out_four)
    else $error("four right shifts of zero left data behind");

  c_load: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode == shift_reg_pkg::MODE_LOAD ##1
    mode == shift_reg_pkg::MODE_RIGHT);
  c_left: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode == shift_reg_pkg::MODE_LEFT [*4]);
  c_idle: cover property (@(posedge clk_sys) disable iff (sys_rst)
    mode == shift_reg_pkg::MODE_IDLE && stage != shift_reg_pkg::STAGE_RESET);
  c_float: cover property (@(posedge clk_sys) disable iff (sys_rst)
    stage_out_oe_n && mode == shift_reg_pkg::MODE_RIGHT);
endmodule // universal_shift_register_4bit
`default_nettype wire

// >>> verification/shift_pins_drv.sv
// pin driver standing in for the logic around the shift register
`timescale 1ns/10ps
`default_nettype none
module shift_pins_drv (
  // clock
  input wire logic clk_sys,
  // driven pins
  output logic [1:0] mode,
  output logic ser_r,
  output logic ser_l,
  output logic [3:0] par,
  output logic oe,
  output logic mrst_n
);
  initial begin
    mode = 2'h0;
    ser_r = 1'h0;
    ser_l = 1'h0;
    par = 4'h0;
    oe = 1'h0;
    mrst_n = 1'h1;
  end
  // pins change only at the falling edge, then stand for n cycles
  task automatic put(input logic [1:0] m, input logic sr, input logic sl,
                     input logic [3:0] d, input logic en, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      mode = m;
      ser_r = sr;
      ser_l = sl;
      par = d;
      oe = en;
    end
  endtask
  task automatic clear(input logic v);
    @(negedge clk_sys);
    mrst_n = v;
  endtask
endmodule // shift_pins_drv
`default_nettype wire

// >>> verification/universal_shift_register_4bit_tb.sv
// self-checking bench for both variants of the shift register
`timescale 1ns/10ps
`default_nettype none
module universal_shift_register_4bit_tb;
  localparam logic [1:0] M_ID = shift_reg_pkg::MODE_IDLE;
  localparam logic [1:0] M_RT = shift_reg_pkg::MODE_RIGHT;
  localparam logic [1:0] M_LF = shift_reg_pkg::MODE_LEFT;
  localparam logic [1:0] M_LD = shift_reg_pkg::MODE_LOAD;
  localparam int PW = shift_reg_pkg::PIN_WIDTH;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [1:0] mode;
  logic ser_r, ser_l, oe, mrst_n;
  logic [3:0] par, q0, q1, e0, e1;
  logic oen0, oen1;
  logic [PW-1:0] pins, p1, p2;
  int fails = 0;
  int n_tests = 0;
  always #25 clk_sys = ~clk_sys;
  assign pins = {oe, par, ser_l, ser_r, mode};
  shift_pins_drv u_drv (.clk_sys(clk_sys), .mode(mode), .ser_r(ser_r),
    .ser_l(ser_l), .par(par), .oe(oe), .mrst_n(mrst_n));
  // both variants side by side on the same pins
  universal_shift_register_4bit #(.VARIANT(shift_reg_pkg::VARIANT_TRISTATE),
    .STAGES(4)) u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .mode_select_first(mode[0]), .mode_select_second(mode[1]),
    .serial_in_rightward(ser_r), .serial_in_leftward(ser_l),
    .parallel_in(par), .output_enable(oe), .master_reset_n(mrst_n),
    .stage_out(q0), .stage_out_oe_n(oen0));
  universal_shift_register_4bit #(.VARIANT(shift_reg_pkg::VARIANT_ASYNC_RESET),
    .STAGES(4)) u_dut_ar (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .mode_select_first(mode[0]), .mode_select_second(mode[1]),
    .serial_in_rightward(ser_r), .serial_in_leftward(ser_l),
    .parallel_in(par), .output_enable(oe), .master_reset_n(mrst_n),
    .stage_out(q1), .stage_out_oe_n(oen1));
  // reference: pins reach the core two edges late, acted on at the third
  function automatic logic [3:0] act(input logic [3:0] c,
                                     input logic [PW-1:0] p, input logic hold);
    case (p[1:0])
      M_RT: return {c[2:0], p[shift_reg_pkg::POS_SER_RIGHT]};
      M_LF: return {p[shift_reg_pkg::POS_SER_LEFT], c[3:1]};
      M_LD: return p[shift_reg_pkg::POS_PAR +: 4];
      default: return hold ? c : 4'h0;
    endcase
  endfunction
  always @(posedge clk_sys) begin
    p1 <= sys_rst ? '0 : pins;
    p2 <= sys_rst ? '0 : p1;
    e0 <= sys_rst ? 4'h0 : act(e0, p2, 1'h0);
  end
  always @(posedge clk_sys or negedge mrst_n) begin
    if (!mrst_n) begin
      e1 <= 4'h0;
    end else begin
      e1 <= sys_rst ? 4'h0 : act(e1, p2, 1'h1);
    end
  end
  task automatic chk_stage(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t stage got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t enable got %b exp %b", $time, got, exp);
    end
  endtask
  always @(negedge clk_sys) begin
    #2;
    if (!sys_rst) begin
      chk_stage(q0, e0);
      chk_stage(q1, e1);
      chk_flag(oen0, ~p2[shift_reg_pkg::POS_OE]);
      chk_flag(oen1, 1'h0);
    end
  end
  task automatic test_done;
    if (fails == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'h0;
    u_drv.put(M_LD, 1'h1, 1'h1, 4'ha, 1'h1, 3);
    u_drv.put(M_RT, 1'h1, 1'h0, 4'h0, 1'h1, 1);
    u_drv.put(M_RT, 1'h0, 1'h1, 4'hf, 1'h1, 1);
    u_drv.put(M_RT, 1'h1, 1'h1, 4'h0, 1'h1, 2);
    u_drv.put(M_LF, 1'h0, 1'h1, 4'h0, 1'h1, 1);
    u_drv.put(M_LF, 1'h1, 1'h0, 4'hf, 1'h1, 2);
    u_drv.put(M_ID, 1'h1, 1'h1, 4'hf, 1'h1, 4);
    u_drv.put(M_LD, 1'h0, 1'h0, 4'h9, 1'h0, 3);
    u_drv.put(M_RT, 1'h1, 1'h0, 4'h0, 1'h0, 3);
    u_drv.put(M_LD, 1'h1, 1'h1, 4'h6, 1'h1, 1);
    u_drv.put(M_RT, 1'h0, 1'h1, 4'h0, 1'h1, 1);
    u_drv.put(M_LF, 1'h0, 1'h1, 4'h0, 1'h1, 1);
    u_drv.put(M_LD, 1'h0, 1'h0, 4'hc, 1'h1, 3);
    u_drv.clear(1'h0);
    u_drv.put(M_LD, 1'h1, 1'h1, 4'h3, 1'h1, 3);
    u_drv.put(M_ID, 1'h0, 1'h0, 4'h0, 1'h1, 3);
    u_drv.clear(1'h1);
    u_drv.put(M_LF, 1'h1, 1'h1, 4'h0, 1'h1, 4);
    // one-edge reset pulse in mid-run must clear both variants
    @(negedge clk_sys);
    sys_rst = 1'h1;
    @(negedge clk_sys);
    sys_rst = 1'h0;
    u_drv.put(M_LD, 1'h0, 1'h0, 4'hd, 1'h1, 3);
    u_drv.put(M_RT, 1'h0, 1'h1, 4'h0, 1'h1, 5);
    repeat (3) @(negedge clk_sys);
    test_done();
  end
endmodule // universal_shift_register_4bit_tb
`default_nettype wire
